// ===== rtl/podc_pkg.sv
// Package: register map, field layout and shared types of the pad configuration block
package podc_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 16;
  localparam logic [11:0] IDX_PAD_CFG1  = 12'hF3C;
  localparam logic [11:0] IDX_PAD_STAT  = 12'hF3D;
  localparam logic [11:0] IDX_OD_CTRL3  = 12'hF40;
  localparam logic [11:0] IDX_OD_CTRL2  = 12'hF41;
  localparam logic [11:0] IDX_OD_CTRL1  = 12'hF42;
  localparam logic [15:0] ADDR_PAD_CFG1 = {2'h0, IDX_PAD_CFG1, 2'h0};
  localparam logic [15:0] ADDR_PAD_STAT = {2'h0, IDX_PAD_STAT, 2'h0};
  localparam logic [15:0] ADDR_OD_CTRL3 = {2'h0, IDX_OD_CTRL3, 2'h0};
  localparam logic [15:0] ADDR_OD_CTRL2 = {2'h0, IDX_OD_CTRL2, 2'h0};
  localparam logic [15:0] ADDR_OD_CTRL1 = {2'h0, IDX_OD_CTRL1, 2'h0};

  // ----------------------------------------------------------------
  // Reset values and implemented-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PAD_CFG1  = 8'h00;
  localparam logic [7:0] RST_OD_CTRL3  = 8'h00;
  localparam logic [7:0] RST_OD_CTRL2  = 8'h00;
  localparam logic [7:0] RST_OD_CTRL1  = 8'h00;
  localparam logic [7:0] MASK_PAD_CFG1 = 8'h07;
  localparam logic [7:0] MASK_OD_CTRL3 = 8'h83;
  localparam logic [7:0] MASK_OD_CTRL2 = 8'h0F;
  localparam logic [7:0] MASK_OD_CTRL1 = 8'hFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OD3_DELAY_IN_BIT = 7;
  localparam int OD3_SYNC2_BIT    = 1;
  localparam int OD3_SYNC1_BIT    = 0;
  localparam int OD2_CAP10_BIT    = 3;
  localparam int OD2_CAP9_BIT     = 2;
  localparam int OD2_SER2_BIT     = 1;
  localparam int OD2_SER1_BIT     = 0;
  localparam int PAD_TTL_BIT      = 0;
  localparam int PAD_SRC_LSB      = 1;
  localparam int STAT_DELAY_BIT   = 0;
  localparam int STAT_CAL_BIT     = 1;

  // ----------------------------------------------------------------
  // Peripheral sources on the remappable pins, and bus answers
  // ----------------------------------------------------------------
  localparam int          NUM_SRC     = 18;
  localparam int          SEL_W       = 5;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CAL_ALARM   = 2'h0,
    CAL_SECONDS = 2'h1,
    CAL_SRC_CLK = 2'h2,
    CAL_RSVD    = 2'h3
  } podc_cal_sel_t;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_PAD_CFG1,
    REG_PAD_STAT,
    REG_OD_CTRL1,
    REG_OD_CTRL2,
    REG_OD_CTRL3
  } podc_reg_t;

  typedef struct packed {
    logic alarm_pulse;
    logic seconds_clk;
    logic internal_rc_osc;
    logic secondary_osc;
    logic timer_ext_clock_in;
  } podc_cal_src_t;

endpackage

// ===== rtl/podc_pad_drive.sv
// Pad driver: per-pin source select, open-drain and latch/direction control
`timescale 1ns/1ps
`default_nettype none
module podc_pad_drive #(
  parameter int NPIN  = 8,
  parameter int NSRC  = podc_pkg::NUM_SRC,
  parameter int SEL_W = podc_pkg::SEL_W
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Sources and settings
  input  wire logic [NSRC-1:0]       periph_out,
  input  wire logic [NSRC-1:0]       od_en,
  input  wire logic [NPIN*SEL_W-1:0] pin_sel,
  input  wire logic [NPIN-1:0]       output_latch,
  input  wire logic [NPIN-1:0]       direction_bit,
  // Pads
  output logic      [NPIN-1:0]       pad_out_ff,
  output logic      [NPIN-1:0]       pad_oe_ff
);
  logic [NPIN-1:0] nxt_pad_out;
  logic [NPIN-1:0] nxt_pad_oe;

  always_comb begin
    int s;
    s = 0;
    nxt_pad_out = '0;
    nxt_pad_oe  = '0;
    for (int i = 0; i < NPIN; i++) begin
      s = int'(pin_sel[i*SEL_W +: SEL_W]);
      if (s == 0 || s > NSRC) begin
        // Plain port pin: low latch plus direction gives a pull-up line
        nxt_pad_out[i] = output_latch[i];
        nxt_pad_oe[i]  = ~direction_bit[i];
      end else begin
        // Open-drain setting travels with the source, not the pin
        nxt_pad_out[i] = periph_out[s-1];
        nxt_pad_oe[i]  = od_en[s-1] ? ~periph_out[s-1] : 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out_ff <= '0;
      pad_oe_ff  <= '0;
    end else begin
      pad_out_ff <= nxt_pad_out;
      pad_oe_ff  <= nxt_pad_oe;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/podc_cal_out.sv
// Calendar clock output pin: source select and enable
`timescale 1ns/1ps
`default_nettype none
module podc_cal_out (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Sources and settings
  input  wire podc_pkg::podc_cal_src_t src,
  input  wire logic [1:0]              calendar_out_source_sel,
  input  wire logic                    calendar_osc_config,
  input  wire logic                    secondary_osc_enable,
  input  wire logic                    calendar_out_enable,
  // Pin
  output logic                         cal_out_ff,
  output logic                         cal_oe_ff
);
  localparam int W = $bits(podc_pkg::podc_cal_src_t);
  podc_pkg::podc_cal_src_t s1_ff, s2_ff, s3_ff, filt_ff;
  logic                    src_clk;
  logic                    nxt_cal_out;

  // Foreign clocks: three stages, a change counts once stages 2 and 3 agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff   <= '0;
      s2_ff   <= '0;
      s3_ff   <= '0;
      filt_ff <= '0;
    end else begin
      s1_ff <= src;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) filt_ff[i] <= s3_ff[i];
      end
    end
  end

  always_comb begin
    src_clk = filt_ff.internal_rc_osc;
    if (calendar_osc_config) begin
      src_clk = secondary_osc_enable ? filt_ff.secondary_osc : filt_ff.timer_ext_clock_in;
    end
    case (podc_pkg::podc_cal_sel_t'(calendar_out_source_sel))
      podc_pkg::CAL_ALARM:   nxt_cal_out = filt_ff.alarm_pulse;
      podc_pkg::CAL_SECONDS: nxt_cal_out = filt_ff.seconds_clk;
      podc_pkg::CAL_SRC_CLK: nxt_cal_out = src_clk;
      default:               nxt_cal_out = 1'b0;
    endcase
  end

  // The select alone never opens the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_out_ff <= 1'b0;
      cal_oe_ff  <= 1'b0;
    end else begin
      cal_out_ff <= calendar_out_enable & nxt_cal_out;
      cal_oe_ff  <= calendar_out_enable;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/podc_regs.sv
// Pad open-drain and pad configuration registers behind an AXI4-Lite slave
//
// Functional notes
// - Register 1: capture 8..4, enhanced 3..1 enables
// - Register 2: capture 10,9, serial 2,1; upper zero
// - Register 3: sync ports 2,1; bits 6-2 zero
// - Register 3 bit 7 routes port A pin 1
// - Open-drain only on serial, sync, capture outputs
// - Open-drain setting follows remapped peripheral pin
// - Open-drain high releases line, pull-up sets level
// - Pad config bit 0 selects TTL buffers
// - Bits 2-1 pick alarm, seconds, source clock
// - Source clock from RC, secondary or external
// - Calendar pin driven only with its enable
// - Low latch: direction bit toggles low/release
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module podc_regs #(
  parameter int NPIN = 8
) (
  // Clock and reset
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  // AXI4-Lite write address
  input  wire logic [podc_pkg::ADDR_W-1:0]           s_axil_awaddr,
  input  wire logic                                  s_axil_awvalid,
  output logic                                       s_axil_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                           s_axil_wdata,
  input  wire logic [3:0]                            s_axil_wstrb,
  input  wire logic                                  s_axil_wvalid,
  output logic                                       s_axil_wready,
  // AXI4-Lite write response
  output logic [1:0]                                 s_axil_bresp,
  output logic                                       s_axil_bvalid,
  input  wire logic                                  s_axil_bready,
  // AXI4-Lite read
  input  wire logic [podc_pkg::ADDR_W-1:0]           s_axil_araddr,
  input  wire logic                                  s_axil_arvalid,
  output logic                                       s_axil_arready,
  output logic [31:0]                                s_axil_rdata,
  output logic [1:0]                                 s_axil_rresp,
  output logic                                       s_axil_rvalid,
  input  wire logic                                  s_axil_rready,
  // Peripheral outputs and pin mapping
  input  wire logic [podc_pkg::NUM_SRC-1:0]          periph_out,
  input  wire logic [NPIN*podc_pkg::SEL_W-1:0]       pin_sel,
  input  wire logic [NPIN-1:0]                       output_latch,
  input  wire logic [NPIN-1:0]                       direction_bit,
  output logic      [NPIN-1:0]                       pad_out,
  output logic      [NPIN-1:0]                       pad_oe,
  // Charge timing unit
  input  wire logic                                  port_a_pin_1,
  output logic                                       charge_timer_delay_in,
  // Parallel master port
  output logic                                       parallel_port_ttl_select,
  // Calendar clock output
  input  wire podc_pkg::podc_cal_src_t               cal_src,
  input  wire logic                                  calendar_osc_config,
  input  wire logic                                  secondary_osc_enable,
  input  wire logic                                  calendar_out_enable,
  output logic                                       calendar_clock_out,
  output logic                                       calendar_clock_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]                  pad_cfg1_ff;
  logic [7:0]                  od_ctrl1_ff;
  logic [7:0]                  od_ctrl2_ff;
  logic [7:0]                  od_ctrl3_ff;
  logic                        awready_ff;
  logic                        wready_ff;
  logic                        bvalid_ff;
  logic [1:0]                  bresp_ff;
  logic                        arready_ff;
  logic                        rvalid_ff;
  logic [1:0]                  rresp_ff;
  logic [31:0]                 rdata_ff;
  logic                        aw_got_ff;
  logic                        w_got_ff;
  logic [podc_pkg::ADDR_W-1:0] awaddr_ff;
  logic [7:0]                  wdata_ff;
  logic                        wstrb0_ff;
  logic                        wr_fire;
  podc_pkg::podc_reg_t         wr_reg;
  logic [7:0]                  nxt_wbyte;
  logic [podc_pkg::NUM_SRC-1:0] od_vec;
  logic                        pa1_s1_ff, pa1_s2_ff, pa1_s3_ff, pa1_filt_ff;
  logic                        delay_in_ff;
  logic                        ttl_ff;
  logic                        cal_out_w;
  logic                        cal_oe_w;

  // ----------------------------------------------------------------
  // Address decode, shared by both directions
  // ----------------------------------------------------------------
  function automatic podc_pkg::podc_reg_t decode(input logic [podc_pkg::ADDR_W-1:0] a);
    case (a)
      podc_pkg::ADDR_PAD_CFG1: decode = podc_pkg::REG_PAD_CFG1;
      podc_pkg::ADDR_PAD_STAT: decode = podc_pkg::REG_PAD_STAT;
      podc_pkg::ADDR_OD_CTRL1: decode = podc_pkg::REG_OD_CTRL1;
      podc_pkg::ADDR_OD_CTRL2: decode = podc_pkg::REG_OD_CTRL2;
      podc_pkg::ADDR_OD_CTRL3: decode = podc_pkg::REG_OD_CTRL3;
      default:                 decode = podc_pkg::REG_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------
  assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign wr_reg  = decode(awaddr_ff);
  assign nxt_wbyte = wdata_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      aw_got_ff  <= 1'b0;
      awaddr_ff  <= '0;
    end else if (s_axil_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      aw_got_ff  <= 1'b1;
      awaddr_ff  <= s_axil_awaddr;
    end else if (wr_fire) begin
      aw_got_ff <= 1'b0;
    end else if (!aw_got_ff && !bvalid_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      wdata_ff  <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else if (s_axil_wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      w_got_ff  <= 1'b1;
      wdata_ff  <= s_axil_wdata[7:0];
      wstrb0_ff <= s_axil_wstrb[0];
    end else if (wr_fire) begin
      w_got_ff <= 1'b0;
    end else if (!w_got_ff && !bvalid_ff) begin
      wready_ff <= 1'b1;
    end
  end

  // Unmapped addresses answer SLVERR; status writes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= podc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_reg == podc_pkg::REG_NONE) ? podc_pkg::RESP_SLVERR
                                                  : podc_pkg::RESP_OKAY;
    end else if (bvalid_ff && s_axil_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Only byte lane 0 carries data; unimplemented bits are masked off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_cfg1_ff <= podc_pkg::RST_PAD_CFG1;
      od_ctrl1_ff <= podc_pkg::RST_OD_CTRL1;
      od_ctrl2_ff <= podc_pkg::RST_OD_CTRL2;
      od_ctrl3_ff <= podc_pkg::RST_OD_CTRL3;
    end else if (wr_fire && wstrb0_ff) begin
      case (wr_reg)
        podc_pkg::REG_PAD_CFG1: pad_cfg1_ff <= nxt_wbyte & podc_pkg::MASK_PAD_CFG1;
        podc_pkg::REG_OD_CTRL1: od_ctrl1_ff <= nxt_wbyte & podc_pkg::MASK_OD_CTRL1;
        podc_pkg::REG_OD_CTRL2: od_ctrl2_ff <= nxt_wbyte & podc_pkg::MASK_OD_CTRL2;
        podc_pkg::REG_OD_CTRL3: od_ctrl3_ff <= nxt_wbyte & podc_pkg::MASK_OD_CTRL3;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read channel: one read at a time, answer one edge after address
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_mux(input podc_pkg::podc_reg_t r);
    read_mux = 32'h0000_0000;
    case (r)
      podc_pkg::REG_PAD_CFG1: read_mux[7:0] = pad_cfg1_ff;
      podc_pkg::REG_OD_CTRL1: read_mux[7:0] = od_ctrl1_ff;
      podc_pkg::REG_OD_CTRL2: read_mux[7:0] = od_ctrl2_ff;
      podc_pkg::REG_OD_CTRL3: read_mux[7:0] = od_ctrl3_ff;
      podc_pkg::REG_PAD_STAT: begin
        read_mux[podc_pkg::STAT_DELAY_BIT] = delay_in_ff;
        read_mux[podc_pkg::STAT_CAL_BIT]   = cal_out_w;
      end
      default: ;
    endcase
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= podc_pkg::RESP_OKAY;
      rdata_ff   <= 32'h0000_0000;
    end else if (s_axil_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= read_mux(decode(s_axil_araddr));
      rresp_ff   <= (decode(s_axil_araddr) == podc_pkg::REG_NONE) ? podc_pkg::RESP_SLVERR
                                                                  : podc_pkg::RESP_OKAY;
    end else if (rvalid_ff && s_axil_rready) begin
      rvalid_ff <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Open-drain enables per source, in periph_out order
  // ----------------------------------------------------------------
  // Only serial, sync-port and capture outputs have an enable at all
  assign od_vec = { {2{od_ctrl3_ff[podc_pkg::OD3_SYNC2_BIT]}},
                    {2{od_ctrl3_ff[podc_pkg::OD3_SYNC1_BIT]}},
                    {2{od_ctrl2_ff[podc_pkg::OD2_SER2_BIT]}},
                    {2{od_ctrl2_ff[podc_pkg::OD2_SER1_BIT]}},
                    od_ctrl2_ff[podc_pkg::OD2_CAP10_BIT],
                    od_ctrl2_ff[podc_pkg::OD2_CAP9_BIT],
                    od_ctrl1_ff };

  podc_pad_drive #(
    .NPIN  (NPIN),
    .NSRC  (podc_pkg::NUM_SRC),
    .SEL_W (podc_pkg::SEL_W)
  ) u_pad_drive (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .periph_out    (periph_out),
    .od_en         (od_vec),
    .pin_sel       (pin_sel),
    .output_latch  (output_latch),
    .direction_bit (direction_bit),
    .pad_out_ff    (pad_out),
    .pad_oe_ff     (pad_oe)
  );

  // ----------------------------------------------------------------
  // Charge timing delay input and buffer select
  // ----------------------------------------------------------------
  // Pin is asynchronous: three stages, filtered on agreement of 2 and 3
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa1_s1_ff   <= 1'b0;
      pa1_s2_ff   <= 1'b0;
      pa1_s3_ff   <= 1'b0;
      pa1_filt_ff <= 1'b0;
    end else begin
      pa1_s1_ff <= port_a_pin_1;
      pa1_s2_ff <= pa1_s1_ff;
      pa1_s3_ff <= pa1_s2_ff;
      if (pa1_s2_ff == pa1_s3_ff) pa1_filt_ff <= pa1_s3_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_in_ff <= 1'b0;
      ttl_ff      <= 1'b0;
    end else begin
      delay_in_ff <= od_ctrl3_ff[podc_pkg::OD3_DELAY_IN_BIT] & pa1_filt_ff;
      ttl_ff      <= pad_cfg1_ff[podc_pkg::PAD_TTL_BIT];
    end
  end

  assign charge_timer_delay_in    = delay_in_ff;
  assign parallel_port_ttl_select = ttl_ff;

  // ----------------------------------------------------------------
  // Calendar clock output
  // ----------------------------------------------------------------
  podc_cal_out u_cal_out (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .src                     (cal_src),
    .calendar_out_source_sel (pad_cfg1_ff[podc_pkg::PAD_SRC_LSB +: 2]),
    .calendar_osc_config     (calendar_osc_config),
    .secondary_osc_enable    (secondary_osc_enable),
    .calendar_out_enable     (calendar_out_enable),
    .cal_out_ff              (cal_out_w),
    .cal_oe_ff               (cal_oe_w)
  );

  assign calendar_clock_out = cal_out_w;
  assign calendar_clock_oe  = cal_oe_w;

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  assign s_axil_awready = awready_ff;
  assign s_axil_wready  = wready_ff;
  assign s_axil_bvalid  = bvalid_ff;
  assign s_axil_bresp   = bresp_ff;
  assign s_axil_arready = arready_ff;
  assign s_axil_rvalid  = rvalid_ff;
  assign s_axil_rresp   = rresp_ff;
  assign s_axil_rdata   = rdata_ff;

endmodule
`default_nettype wire

// ===== testbench/podc_monitor.sv
// Checker: bus and pad output assertions at the register block ports
`timescale 1ns/1ps
`default_nettype none
module podc_monitor (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axil_awvalid,
  input wire logic        s_axil_awready,
  input wire logic        s_axil_wvalid,
  input wire logic        s_axil_wready,
  input wire logic [1:0]  s_axil_bresp,
  input wire logic        s_axil_bvalid,
  input wire logic        s_axil_bready,
  input wire logic        s_axil_arvalid,
  input wire logic        s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic        s_axil_rvalid,
  input wire logic        s_axil_rready,
  // Pad side
  input wire logic        parallel_port_ttl_select,
  input wire logic        calendar_clock_out,
  input wire logic        calendar_clock_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_aw_refused: assert property (s_axil_awvalid && s_axil_awready |=> !s_axil_awready)
    else $error("awready high after address taken");
  a_write_answer: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid
    && s_axil_wready |=> ##[0:2] s_axil_bvalid)
    else $error("write response late");
  a_bresp_stands: assert property (s_axil_bvalid && !s_axil_bready
    |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axil_arvalid && s_axil_arready
    |=> s_axil_rvalid && !s_axil_arready)
    else $error("read answer missing");
  a_rdata_stands: assert property (s_axil_rvalid && !s_axil_rready
    |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read data dropped");
  a_rdata_upper: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_ttl_on_write: assert property ($changed(parallel_port_ttl_select)
    |-> s_axil_bvalid || $past(s_axil_bvalid))
    else $error("buffer select moved without write");
  a_cal_gated: assert property (!calendar_clock_oe |-> !calendar_clock_out)
    else $error("calendar pin active while disabled");
endmodule
bind podc_regs podc_monitor u_mon (.aclk, .aresetn, .s_axil_awvalid, .s_axil_awready,
  .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
  .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rvalid, .s_axil_rready,
  .parallel_port_ttl_select, .calendar_clock_out, .calendar_clock_oe);
`default_nettype wire

// ===== testbench/testbench.sv
// Testbench: register access, pad drive and calendar output checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                    aclk, aresetn, port_a_pin_1;
  logic [15:0]             s_axil_awaddr, s_axil_araddr;
  logic [31:0]             s_axil_wdata, s_axil_rdata;
  logic [3:0]              s_axil_wstrb;
  logic [1:0]              s_axil_bresp, s_axil_rresp;
  logic                    s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic                    s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
  logic                    s_axil_rvalid, s_axil_rready;
  logic [17:0]             periph_out;
  logic [39:0]             pin_sel;
  logic [7:0]              output_latch, direction_bit, pad_out, pad_oe;
  logic                    charge_timer_delay_in, parallel_port_ttl_select;
  podc_pkg::podc_cal_src_t cal_src;
  logic                    calendar_osc_config, secondary_osc_enable, calendar_out_enable;
  logic                    calendar_clock_out, calendar_clock_oe;
  int                      num_errors = 0;
  int                      n_checks = 0;
  localparam logic [15:0] ADR [4] = '{podc_pkg::ADDR_PAD_CFG1, podc_pkg::ADDR_OD_CTRL3,
                                      podc_pkg::ADDR_OD_CTRL2, podc_pkg::ADDR_OD_CTRL1};
  localparam logic [7:0]  MSK [4] = '{8'h07, 8'h83, 8'h0F, 8'hFF};
  // Rows are {select, osc config, secondary enable, pin enable}
  localparam logic [4:0]  CAL [6] = '{5'h01, 5'h09, 5'h11, 5'h17, 5'h15, 5'h00};
  localparam logic [5:0]  CAL_EXP = 6'h15;

  podc_regs u_dut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
    .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
    .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .periph_out, .pin_sel,
    .output_latch, .direction_bit, .pad_out, .pad_oe, .port_a_pin_1,
    .charge_timer_delay_in, .parallel_port_ttl_select, .cal_src, .calendar_osc_config,
    .secondary_osc_enable, .calendar_out_enable, .calendar_clock_out, .calendar_clock_oe);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axil_awvalid && s_axil_awready) begin
        aw_done = 1'b1;
        s_axil_awvalid <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_done = 1'b1;
        s_axil_wvalid <= 1'b0;
      end
    end
    repeat (2) @(posedge aclk);
    s_axil_bready <= 1'b1;
    do @(posedge aclk); while (!s_axil_bvalid);
    r = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axil_arready);
    s_axil_arvalid <= 1'b0;
    @(posedge aclk);
    s_axil_rready <= 1'b1;
    do @(posedge aclk); while (!s_axil_rvalid);
    d = s_axil_rdata;
    r = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    end_of_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    aresetn = 1'b0;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = 5'h00;
    s_axil_awaddr = 16'h0000;
    s_axil_araddr = 16'h0000;
    s_axil_wdata = 32'h00000000;
    s_axil_wstrb = 4'hF;
    periph_out = 18'h3FFFF;
    pin_sel = {25'h0000000, 5'h01, 5'h0B, 5'h00};
    output_latch = 8'hFF;
    direction_bit = 8'h00;
    port_a_pin_1 = 1'b1;
    cal_src = 5'h15;
    {calendar_osc_config, secondary_osc_enable, calendar_out_enable} = 3'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ADR[i], d, r);
      chk(d, 32'h00000000);
    end
    chk(32'(charge_timer_delay_in), 32'h00000000);
    // Every bit set; only implemented bits may stick
    for (int i = 0; i < 4; i++) begin
      wr(ADR[i], 32'hFFFFFFFF, r);
      chk(32'(r), 32'(podc_pkg::RESP_OKAY));
      rd(ADR[i], d, r);
      chk(d, 32'(MSK[i]));
    end
    repeat (8) @(posedge aclk);
    chk(32'(parallel_port_ttl_select), 32'h00000001);
    chk(32'(charge_timer_delay_in), 32'h00000001);
    chk(32'({pad_out[0], pad_oe[2:0]}), 32'h00000009);
    port_a_pin_1 <= 1'b0;
    wr(16'h0100, 32'h00000001, r);
    chk(32'(r), 32'(podc_pkg::RESP_SLVERR));
    rd(16'h0100, d, r);
    chk(d, 32'h00000000);
    chk(32'(r), 32'(podc_pkg::RESP_SLVERR));
    chk(32'(charge_timer_delay_in), 32'h00000000);
    port_a_pin_1 <= 1'b1;
    wr(podc_pkg::ADDR_OD_CTRL2, 32'h00000000, r);
    repeat (3) @(posedge aclk);
    chk(32'({pad_out[1], pad_oe[2:0]}), 32'h0000000B);
    // Swap peripherals between pins
    pin_sel <= {25'h0000000, 5'h0B, 5'h01, 5'h00};
    repeat (3) @(posedge aclk);
    chk(32'({pad_out[2], pad_oe[2:0]}), 32'h0000000D);
    output_latch <= 8'h00;
    direction_bit <= 8'h01;
    repeat (3) @(posedge aclk);
    chk(32'(pad_oe[0]), 32'h00000000);
    direction_bit <= 8'h00;
    repeat (3) @(posedge aclk);
    chk(32'({pad_out[0], pad_oe[0]}), 32'h00000001);
    wr(podc_pkg::ADDR_OD_CTRL3, 32'h00000003, r);
    repeat (8) @(posedge aclk);
    chk(32'(charge_timer_delay_in), 32'h00000000);
    for (int i = 0; i < 6; i++) begin
      wr(podc_pkg::ADDR_PAD_CFG1, {29'h00000000, CAL[i][4:3], 1'b0}, r);
      {calendar_osc_config, secondary_osc_enable, calendar_out_enable} <= CAL[i][2:0];
      repeat (8) @(posedge aclk);
      chk(32'({calendar_clock_oe, calendar_clock_out}), 32'({CAL[i][0], CAL_EXP[i]}));
    end
    chk(32'(parallel_port_ttl_select), 32'h00000000);
    end_of_test();
  end
endmodule
`default_nettype wire
